// File: sacc_pkg.sv
// Constants, register map and state codes for the 8-bit SAR converter control.
// Assumes a 32-bit APB master and an analog front end with a comparator.
// Notes on behaviour
// - Result is 8 bits, resolved one bit per step by successive approximation.
// - Conversion survives sleep only with the internal RC clock selected.
// - Clock select 00/01/10/11 gives clock /2, /8, /32, RC oscillator.
// - Three-bit channel select routes channel 0 to 7 to the sampler.
// - Small variant implements channels 0 to 4 only; large has eight.
// - Writing one to go bit 2 starts conversion while powered on.
// - Hardware clears the go bit when a conversion finishes.
// - Power bit 0 enables converter; clear means off, no operating current.
// - Port map register bits 7 to 3 read zero and ignore writes.
// - Port map code sets each of eight pins analog or digital.
// - Odd map codes 001, 011, 101 use the external reference pin.
// - All implemented control bits reset to zero.
// - Completion loads result, clears go bit and sets the done flag.
// - Clearing go during a conversion aborts; result and flag unchanged.
// - A conversion takes nine per-bit conversion periods.
package sacc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W = 8;
  localparam int unsigned MAP_W = 3;
  localparam int unsigned CHAN_W = 3;
  // Register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h01F;
  localparam logic [9:0] MAP_IDX = 10'h09F;
  localparam logic [9:0] RESULT_IDX = 10'h01E;
  localparam logic [9:0] FLAG_IDX = 10'h00C;
  // Field positions
  localparam int unsigned CTRL_POWER_BIT = 0;
  localparam int unsigned CTRL_GO_BIT = 2;
  localparam int unsigned CTRL_CHAN_LSB = 3;
  localparam int unsigned CTRL_CLK_LSB = 6;
  localparam int unsigned FLAG_DONE_BIT = 6;
  // Reset values
  localparam logic [1:0] CLK_RST = 2'h0;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [2:0] MAP_RST = 3'h0;
  localparam logic [7:0] RES_RST = 8'h00;
  // Conversion clock codes and prescaler terminal counts
  typedef enum logic [1:0] {
    SACC_DIV2 = 2'h0,
    SACC_DIV8 = 2'h1,
    SACC_DIV32 = 2'h2,
    SACC_RC = 2'h3
  } sacc_clk_t;
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // Trial bit masks: first guess is the MSB, last is the LSB
  localparam logic [7:0] TRIAL_FIRST = 8'h80;
  localparam logic [7:0] TRIAL_LAST = 8'h01;
  // Pin masks, bit n is analog channel n; channel 3 doubles as the reference pin
  localparam logic [7:0] PINS_ALL = 8'hFF;
  localparam logic [7:0] PINS_LOW5 = 8'h1F;
  localparam logic [7:0] PINS_CH013 = 8'h0B;
  localparam logic [7:0] PINS_VREF = 8'h08;
  localparam logic [7:0] PINS_NONE = 8'h00;
  typedef enum logic [1:0] {
    SACC_IDLE = 2'h0,
    SACC_SAMP = 2'h1,
    SACC_CONV = 2'h3
  } sacc_state_t;
endpackage : sacc_pkg

// File: sacc_top.sv
// APB-reached control for an 8-bit successive-approximation converter.
// Assumes an external comparator, sample switch and DAC, and an RC tick input.
`timescale 1ns/1ps
module sacc_top #(
  parameter int NUM_CHAN = 8
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sacc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [sacc_pkg::DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [sacc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // System state
  input wire logic SLEEP,
  input wire logic RC_TICK,
  // Analog front end
  input wire logic COMP_HI,
  output logic [sacc_pkg::RES_W-1:0] DAC_CODE,
  output logic [sacc_pkg::CHAN_W-1:0] CHAN_SEL,
  output logic CHAN_OK,
  output logic SAMPLE_HOLD,
  output logic ANALOG_EN,
  output logic REF_EXT,
  output logic [7:0] PIN_ANALOG,
  output logic CONV_DONE_FLAG
);
  import sacc_pkg::*;

  logic rst_q1;
  logic rst_n_s;
  logic [7:0] chan_impl;

  // Control and status state
  sacc_clk_t clk_sel;
  logic [2:0] chan;
  logic go;
  logic power;
  logic [2:0] port_map;
  logic [7:0] result;
  logic done_flag;
  sacc_state_t state;
  logic [4:0] pre;
  logic [7:0] sar;
  logic [7:0] trial;
  logic [31:0] rdata;
  logic ready;
  logic slverr;
  logic hold;
  logic anen;
  logic ref_ext;
  logic [7:0] pins;
  logic chan_ok;

  sacc_clk_t next_clk_sel;
  logic [2:0] next_chan;
  logic next_go;
  logic next_power;
  logic [2:0] next_port_map;
  logic [7:0] next_result;
  logic next_done_flag;
  sacc_state_t next_state;
  logic [4:0] next_pre;
  logic [7:0] next_sar;
  logic [7:0] next_trial;
  logic [31:0] next_rdata;
  logic next_ready;
  logic next_slverr;
  logic next_hold;
  logic next_anen;
  logic next_ref_ext;
  logic [7:0] next_pins;
  logic next_chan_ok;

  // Reset released through two flops so release is glitch free
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  // Channels beyond the variant's count do not exist
  for (genvar g = 0; g < 8; g++) begin : g_impl
    assign chan_impl[g] = (g < NUM_CHAN) ? 1'b1 : 1'b0;
  end

  function automatic logic [7:0] sacc_pin_mask(input logic [2:0] code);
    logic [7:0] m;
    m = PINS_NONE;
    case (code)
      3'h0: m = PINS_ALL;
      3'h1: m = PINS_ALL & ~PINS_VREF;
      3'h2: m = PINS_LOW5;
      3'h3: m = PINS_LOW5 & ~PINS_VREF;
      3'h4: m = PINS_CH013;
      3'h5: m = PINS_CH013 & ~PINS_VREF;
      default: m = PINS_NONE;
    endcase
    return m;
  endfunction : sacc_pin_mask

  logic acc;
  logic wr;
  logic [9:0] idx;
  logic hit;
  logic tick;
  logic stall_sleep;
  logic [4:0] pre_last;
  logic [7:0] sar_eval;

  always_comb begin
    acc = PSEL & PENABLE & PREADY;
    wr = acc & PWRITE & PSTRB[0] & ~PSLVERR;
    idx = PADDR[ADDR_W-1:2];
    hit = (PADDR[1:0] == 2'h0) &&
          (idx == CTRL_IDX || idx == MAP_IDX || idx == RESULT_IDX || idx == FLAG_IDX);
    unique case (clk_sel)
      SACC_DIV2: pre_last = DIV2_LAST;
      SACC_DIV8: pre_last = DIV8_LAST;
      SACC_DIV32: pre_last = DIV32_LAST;
      SACC_RC: pre_last = DIV32_LAST;
    endcase
    // Only the RC clock keeps running while the core sleeps
    stall_sleep = SLEEP & (clk_sel != SACC_RC);
    tick = (clk_sel == SACC_RC) ? RC_TICK : (pre == pre_last);
    // Keep the trial bit when the sample is at or above the DAC level
    sar_eval = COMP_HI ? sar : (sar & ~trial);

    next_clk_sel = clk_sel;
    next_chan = chan;
    next_go = go;
    next_power = power;
    next_port_map = port_map;
    next_result = result;
    next_done_flag = done_flag;
    next_state = state;
    next_pre = pre;
    next_sar = sar;
    next_trial = trial;
    next_hold = hold;

    // Software writes; the done flag is cleared by writing zero
    if (wr && idx == CTRL_IDX) begin
      next_clk_sel = sacc_clk_t'(PWDATA[CTRL_CLK_LSB +: 2]);
      next_chan = PWDATA[CTRL_CHAN_LSB +: CHAN_W];
      next_power = PWDATA[CTRL_POWER_BIT];
      if (PWDATA[CTRL_GO_BIT] && power && state == SACC_IDLE) begin
        next_go = 1'b1;
        next_state = SACC_SAMP;
        next_pre = '0;
        next_sar = TRIAL_FIRST;
        next_trial = TRIAL_FIRST;
        next_hold = 1'b1;
      end else if (!PWDATA[CTRL_GO_BIT]) begin
        next_go = 1'b0;
      end
    end
    if (wr && idx == MAP_IDX) begin
      next_port_map = PWDATA[MAP_W-1:0];
    end
    if (wr && idx == FLAG_IDX) begin
      next_done_flag = PWDATA[FLAG_DONE_BIT];
    end

    // Conversion engine; an abort leaves result and flag alone
    unique case (state)
      SACC_IDLE: begin
      end
      SACC_SAMP, SACC_CONV: begin
        // One period samples, eight more decide the bits, MSB first
        next_pre = tick ? 5'h00 : 5'(pre + 5'h01);
        if (!next_go || !next_power || stall_sleep) begin
          next_go = 1'b0;
          next_state = SACC_IDLE;
          next_hold = 1'b0;
        end else if (tick && state == SACC_SAMP) begin
          next_state = SACC_CONV;
        end else if (tick) begin
          next_sar = sar_eval | (trial >> 1);
          next_trial = trial >> 1;
          if (trial == TRIAL_LAST) begin
            next_result = sar_eval;
            next_go = 1'b0;
            next_done_flag = 1'b1; // Set beats a same-cycle clear
            next_state = SACC_IDLE;
            next_hold = 1'b0;
          end
        end
      end
      default: begin
        next_state = SACC_IDLE;
        next_go = 1'b0;
        next_hold = 1'b0;
      end
    endcase

    // Pin and power outputs follow the next state so they never lag a write, except the sleep gate, which uses the current clock select
    next_anen = next_power & ~stall_sleep;
    next_ref_ext = next_port_map[0] & ~(next_port_map[2] & next_port_map[1]);
    next_pins = sacc_pin_mask(next_port_map) & chan_impl;
    next_chan_ok = chan_impl[next_chan];
  end

  // Bus answer: a registered reply costs one wait state but keeps outputs straight from flops
  always_comb begin
    next_ready = PSEL & PENABLE & ~PREADY;
    // Unmapped or misaligned access answers with an error and zero data
    next_slverr = PSEL & PENABLE & ~PREADY & ~hit;
    next_rdata = PRDATA;
    // Reads see the registers as they stand before the edge that raises PREADY, one cycle ahead of the completing edge
    if (PSEL && PENABLE && !PREADY) begin
      next_rdata = '0;
      if (PADDR[1:0] == 2'h0) begin
        if (idx == CTRL_IDX) begin
          next_rdata[CTRL_CLK_LSB +: 2] = clk_sel;
          next_rdata[CTRL_CHAN_LSB +: CHAN_W] = chan;
          next_rdata[CTRL_GO_BIT] = go;
          next_rdata[CTRL_POWER_BIT] = power;
        end else if (idx == MAP_IDX) begin
          next_rdata[MAP_W-1:0] = port_map;
        end else if (idx == RESULT_IDX) begin
          next_rdata[RES_W-1:0] = result;
        end else if (idx == FLAG_IDX) begin
          next_rdata[FLAG_DONE_BIT] = done_flag;
        end
      end
    end
  end

  // Bus answer flops
  always_ff @(posedge MCLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata <= '0;
      ready <= 1'b0;
      slverr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      ready <= next_ready;
      slverr <= next_slverr;
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      clk_sel <= SACC_DIV2;
      chan <= CHAN_RST;
      go <= 1'b0;
      power <= 1'b0;
      port_map <= MAP_RST;
      result <= RES_RST;
      done_flag <= 1'b0;
      state <= SACC_IDLE;
      pre <= '0;
      sar <= '0;
      trial <= '0;
      hold <= 1'b0;
      anen <= 1'b0;
      ref_ext <= 1'b0;
      pins <= PINS_ALL;
      chan_ok <= 1'b1;
    end else begin
      clk_sel <= next_clk_sel;
      chan <= next_chan;
      go <= next_go;
      power <= next_power;
      port_map <= next_port_map;
      result <= next_result;
      done_flag <= next_done_flag;
      state <= next_state;
      pre <= next_pre;
      sar <= next_sar;
      trial <= next_trial;
      hold <= next_hold;
      anen <= next_anen;
      ref_ext <= next_ref_ext;
      pins <= next_pins;
      chan_ok <= next_chan_ok;
    end
  end

  // Outputs are the flops themselves
  assign PRDATA = rdata;
  assign PREADY = ready;
  assign PSLVERR = slverr;
  assign DAC_CODE = sar;
  assign CHAN_SEL = chan;
  assign CHAN_OK = chan_ok;
  assign SAMPLE_HOLD = hold;
  assign ANALOG_EN = anen;
  assign REF_EXT = ref_ext;
  assign PIN_ANALOG = pins;
  assign CONV_DONE_FLAG = done_flag;
endmodule : sacc_top

// File: sacc_top_props.sv
// Port checker for the SAR converter control.
// Assumes the sacc_top port list and the single MCLK domain.
`timescale 1ns/1ps
module sacc_props #(
  parameter int NUM_CHAN = 8
) (
  // Clock, reset and bus answer
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Converter side
  input wire logic [7:0] DAC_CODE,
  input wire logic [2:0] CHAN_SEL,
  input wire logic CHAN_OK,
  input wire logic SAMPLE_HOLD,
  input wire logic ANALOG_EN,
  input wire logic REF_EXT,
  input wire logic [7:0] PIN_ANALOG,
  input wire logic CONV_DONE_FLAG
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wait_state_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  first_trial_a: assert property ($rose(SAMPLE_HOLD) |-> DAC_CODE == 8'h80)
    else $error("first trial not msb");
  flag_source_a: assert property ($rose(CONV_DONE_FLAG) |-> $fell(SAMPLE_HOLD))
    else $error("flag without completion");
  power_abort_a: assert property (!ANALOG_EN |-> ##2 !SAMPLE_HOLD)
    else $error("runs while off");
  ref_pin_a: assert property (REF_EXT |-> !PIN_ANALOG[3])
    else $error("reference pin analog");
  pin_group_a: assert property (PIN_ANALOG[7:5] inside {3'h0, 3'h7} && PIN_ANALOG[1] == PIN_ANALOG[0])
    else $error("pin groups split");
  chan_ok_a: assert property (CHAN_OK == (CHAN_SEL < NUM_CHAN))
    else $error("channel ok wrong");
endmodule : sacc_props
bind sacc_top sacc_props #(.NUM_CHAN(NUM_CHAN)) u_props (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .DAC_CODE(DAC_CODE), .CHAN_SEL(CHAN_SEL),
  .CHAN_OK(CHAN_OK), .SAMPLE_HOLD(SAMPLE_HOLD), .ANALOG_EN(ANALOG_EN), .REF_EXT(REF_EXT),
  .PIN_ANALOG(PIN_ANALOG), .CONV_DONE_FLAG(CONV_DONE_FLAG));

// File: sacc_analog_model.sv
// Analog front end: per-channel levels, comparator and RC ticks.
// Assumes the comparator is only meaningful while the sample is held.
`timescale 1ns/1ps
module sacc_analog_model (
  // Clock
  input wire logic mclk,
  // From the converter
  input wire logic [7:0] dac_code,
  input wire logic [2:0] chan_sel,
  input wire logic sample_hold,
  input wire logic analog_en,
  // To the converter
  output logic comp_hi,
  output logic rc_tick
);
  logic [2:0] rc_cnt = 3'h0;
  logic junk = 1'b0;
  logic [7:0] level;
  // Fixed ramp of levels, one per channel
  always_comb level = 8'(8'h3C + 8'(chan_sel) * 8'h21);
  // Garbage when not held, so nothing leans on a stale compare
  always_comb comp_hi = (sample_hold && analog_en) ? (level >= dac_code) : junk;
  always @(posedge mclk) begin
    junk <= ~junk;
    rc_cnt <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h6);
  end
endmodule : sacc_analog_model

// File: sacc_top_tb_top.sv
// Testbench for the SAR converter control, driven over APB.
// Assumes the analog model on the far side; no reset value is read before sync.
`timescale 1ns/1ps
module sacc_top_tb_top;
  import sacc_pkg::*;
  localparam logic [11:0] A_CTRL = {CTRL_IDX, 2'b00};
  localparam logic [11:0] A_MAP = {MAP_IDX, 2'b00};
  localparam logic [11:0] A_RES = {RESULT_IDX, 2'b00};
  localparam logic [11:0] A_FLAG = {FLAG_IDX, 2'b00};
  localparam logic [7:0] PINS [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, rc_tick, comp_hi, chan_ok, sample_hold, analog_en, ref_ext, done_flag;
  logic [7:0] dac_code, pin_analog;
  logic [2:0] chan_sel;
  logic chan_ok_small;
  logic [7:0] pin_small;
  int failures = 0, cmp_count = 0;
  always #20 mclk = ~mclk;
  sacc_top #(.NUM_CHAN(8)) DUT (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SLEEP(sleep), .RC_TICK(rc_tick), .COMP_HI(comp_hi), .DAC_CODE(dac_code),
    .CHAN_SEL(chan_sel), .CHAN_OK(chan_ok), .SAMPLE_HOLD(sample_hold), .ANALOG_EN(analog_en),
    .REF_EXT(ref_ext), .PIN_ANALOG(pin_analog), .CONV_DONE_FLAG(done_flag));
  sacc_analog_model u_model (.mclk(mclk), .dac_code(dac_code), .chan_sel(chan_sel),
    .sample_hold(sample_hold), .analog_en(analog_en), .comp_hi(comp_hi), .rc_tick(rc_tick));
  // Small variant shares the bus; only its channel and pin outputs are judged
  sacc_top #(.NUM_CHAN(5)) DUT_SMALL (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(), .PREADY(), .PSLVERR(),
    .SLEEP(sleep), .RC_TICK(rc_tick), .COMP_HI(comp_hi), .DAC_CODE(), .CHAN_SEL(), .CHAN_OK(chan_ok_small),
    .SAMPLE_HOLD(), .ANALOG_EN(), .REF_EXT(), .PIN_ANALOG(pin_small), .CONV_DONE_FLAG());
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // One idle edge first, so select never rises in the step it fell; request held until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask : wr
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(0, A_CTRL, 0, r, e);
    check(r, 0);
    apb(0, A_MAP, 0, r, e);
    check(r, 0);
    check({ref_ext, pin_analog}, 9'h0FF);
    apb(0, 12'h004, 0, r, e);
    check(e, 1);
    check(r, 0);
    wr(A_CTRL, 32'hFF);
    apb(0, A_CTRL, 0, r, e);
    check(r, 32'hF9);
    check({done_flag, sample_hold}, 0);
    check(chan_ok_small, 0);
    wr(A_CTRL, 0);
    for (int c = 0; c < 8; c++) begin
      wr(A_MAP, 32'hF8 | c);
      apb(0, A_MAP, 0, r, e);
      check(r, c);
      check(pin_analog, PINS[c]);
      check(pin_small, PINS[c] & PINS_LOW5);
      check(ref_ext, c[0] && c < 6);
    end
    wr(A_MAP, 0);
    $display("test regs done");
  endtask : t_regs
  // Map, then clock and power, acquisition gap, then start; div 0 skips the timing check
  task automatic t_conv(input logic [1:0] cs, input logic [2:0] ch, input int div);
    logic [31:0] r;
    logic e;
    int n;
    wr(A_MAP, 0);
    wr(A_CTRL, {cs, ch, 3'b001});
    repeat (5) @(posedge mclk);
    wr(A_CTRL, {cs, ch, 3'b101});
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (done_flag !== 1'b1 && n < 2000);
    check(n < 2000, 1);
    if (n >= 2000) final_report();
    if (div > 0) check(n, 9 * div);
    apb(0, A_RES, 0, r, e);
    check(r, 8'(8'h3C + 8'(ch) * 8'h21));
    apb(0, A_CTRL, 0, r, e);
    check(r, {cs, ch, 3'b001});
    check(chan_sel, ch);
    check(chan_ok_small, ch < 5);
    apb(0, A_FLAG, 0, r, e);
    check(r, 32'h1 << FLAG_DONE_BIT);
    wr(A_FLAG, 0);
    apb(0, A_FLAG, 0, r, e);
    check(r, 0);
    $display("test conversion %0d done", cs);
  endtask : t_conv
  // Abort by go clear, power off and sleep; result and flag must not move
  task automatic t_abort;
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 3; k++) begin
      wr(A_CTRL, 32'h89);
      wr(A_CTRL, 32'h8D);
      repeat (40) @(posedge mclk);
      if (k == 0) wr(A_CTRL, 32'h89);
      if (k == 1) wr(A_CTRL, 32'h00);
      if (k == 2) sleep <= 1;
      repeat (400) @(posedge mclk);
      check({done_flag, sample_hold}, 0);
      if (k > 0) check(analog_en, 0);
      apb(0, A_RES, 0, r, e);
      check(r, 8'h9F);
      sleep <= 0;
    end
    $display("test abort done");
  endtask : t_abort
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_conv(2'h0, 3'h7, 2);
    t_conv(2'h1, 3'h0, 8);
    t_conv(2'h2, 3'h4, 32);
    sleep <= 1;
    t_conv(2'h3, 3'h3, 0);
    sleep <= 0;
    t_abort();
    final_report();
  end
endmodule : sacc_top_tb_top
